// ==== logic/gpt_timer.sv ====
// timer pair: two 16-bit down-counters, joined 32-bit timer or rtc counter
// assumes an AHB-Lite master with single word transfers, synchronous pins
//
// Function
// - reset: idle, counters and loads all ones
// - reset: prescalers and prescale regs zero
// - config 0 joined timer, 1 rtc
// - config 4 gives two independent 16-bit timers
// - joined acts single timer, split independent
// - joined load write fills both halves
// - joined count read gives b:a halves
// - split uses both pins, joined even only
// - joined mode taken from timer a only
// - joined counts down, reloads, oneshot stops
// - joined timeout sets sticky raw flag
// - trigger pulse one cycle at zero
// - load write while running takes effect at once
// - freeze bit holds count until released
// - rtc counts up, first load one
// - rtc advances on slow clock pin
// - rtc match rolls to zero, continues
// - rtc match sets flag, clear clears it
// - override bit makes rtc ignore freeze
// - split timers 16-bit with 8-bit prescale
// - split zero reloads count and prescale
// - split timeout sets sticky raw flag
// - prescale p gives p+1 clocks per count
`include "gpt_cfg.svh"
module gpt_timer
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [11:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic HREADY,
   input wire logic [31:0] HWDATA,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // slow clock pin, synchronous level
   input wire logic SLOW_CLOCK_PIN,
   // trigger pulses and interrupt
   output logic TRIGGER_A,
   output logic TRIGGER_B,
   output logic TIMER_IRQ,
   // capture compare pin enables
   output logic CAPTURE_COMPARE_PIN_EVEN_EN,
   output logic CAPTURE_COMPARE_PIN_ODD_EN
);
   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [2:0] cfg_reg; // timer_configuration_reg
   logic [1:0] amode_reg; // timer_a_mode_reg
   logic [1:0] bmode_reg; // timer_b_mode_reg
   logic [13:0] ctl_reg; // timer_control_reg
   logic [8:0] mask_reg; // interrupt_mask_reg
   logic [8:0] raw_reg; // raw_status_reg
   logic [15:0] aload_reg; // timer_a_load_reg
   logic [15:0] bload_reg; // timer_b_load_reg
   logic [31:0] amatch_reg; // timer_a_match_reg
   logic [7:0] apre_reg; // timer_a_prescale_reg
   logic [7:0] bpre_reg; // timer_b_prescale_reg
   logic [15:0] acnt_reg; // timer a count
   logic [15:0] bcnt_reg; // timer b count
   logic [7:0] apc_reg; // timer a prescale counter
   logic [7:0] bpc_reg; // timer b prescale counter
   logic rtc_seen_reg; // rtc first-load done
   logic slow_reg; // previous slow clock level
   logic trga_reg; // trigger a flop
   logic trgb_reg; // trigger b flop
   // ahb address phase capture
   logic wr_reg;
   logic [11:0] addr_reg;
   logic [31:0] rdata_reg;

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------
   // counter advances when prescale count reaches zero
   function automatic logic pre_tick(input logic [7:0] pc);
      pre_tick = (pc == 8'h00);
   endfunction

   // ----------------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------------
   gpt_pkg::gpt_join_t join_st;
   wire logic is_j32 = (cfg_reg == `GPT_CFG_32TMR);
   wire logic is_rtc = (cfg_reg == `GPT_CFG_32RTC);
   wire logic is_split = (cfg_reg == `GPT_CFG_16);
   assign join_st = is_rtc ? gpt_pkg::GPT_JRTC :
      (is_j32 ? gpt_pkg::GPT_J32 : gpt_pkg::GPT_SPLIT);
   wire logic joined = is_j32 | is_rtc;
   wire logic a_en = ctl_reg[`GPT_CTL_AEN];
   wire logic b_en = ctl_reg[`GPT_CTL_BEN];
   wire logic frz_any = ctl_reg[`GPT_CTL_AFRZ] | ctl_reg[`GPT_CTL_BFRZ];
   wire logic addr_ok = HSEL & HREADY & HTRANS[1];
   wire logic wr_load_a = wr_reg & (addr_reg == `GPT_OFF_ALOAD);
   wire logic wr_load_b = wr_reg & (addr_reg == `GPT_OFF_BLOAD);
   wire logic wr_ctl = wr_reg & (addr_reg == `GPT_OFF_CTL);
   wire logic wr_clr = wr_reg & (addr_reg == `GPT_OFF_CLR);
   wire logic wr_cfg = wr_reg & (addr_reg == `GPT_OFF_CFG);
   wire logic [31:0] cnt32 = {bcnt_reg, acnt_reg};
   wire logic [31:0] load32 = {bload_reg, aload_reg};
   // rising edge of the slow clock, pin taken as synchronous
   wire logic slow_rise = SLOW_CLOCK_PIN & ~slow_reg;

   // joined timer events
   wire logic j_run = is_j32 & a_en & ~ctl_reg[`GPT_CTL_AFRZ];
   wire logic j_zero = j_run & (cnt32 == 32'h00000000);
   wire logic j_oneshot = (amode_reg == `GPT_MODE_ONESHOT);
   // rtc events; override disregards freeze bits
   wire logic r_run = is_rtc & a_en & rtc_seen_reg &
      (ctl_reg[`GPT_CTL_RTCOVR] | ~frz_any);
   wire logic r_step = r_run & slow_rise;
   wire logic r_match = r_step & (cnt32 == amatch_reg);

   // split timer events
   wire logic a_run = is_split & a_en & ~ctl_reg[`GPT_CTL_AFRZ];
   wire logic b_run = is_split & b_en & ~ctl_reg[`GPT_CTL_BFRZ];
   wire logic a_tick = a_run & pre_tick(apc_reg);
   wire logic b_tick = b_run & pre_tick(bpc_reg);
   wire logic a_zero = a_tick & (acnt_reg == 16'h0000);
   wire logic b_zero = b_tick & (bcnt_reg == 16'h0000);

   // timeout events per status bit
   wire logic ev_ato = j_zero | a_zero;
   wire logic ev_bto = b_zero;
   wire logic [8:0] ev_vec = {ev_bto, 4'h0, r_match, 2'h0, ev_ato};

   // ----------------------------------------------------------------------
   // ahb-lite slave: zero wait, always okay
   // ----------------------------------------------------------------------
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata_reg;

   // address phase capture
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         wr_reg <= 1'b0;
         addr_reg <= 12'h000;
      end
      else
      begin
         wr_reg <= addr_ok & HWRITE;
         addr_reg <= {HADDR[11:2], 2'b00};
      end
   end

   // read mux; unmapped reads as zero
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h00000000;
      case (HADDR[11:0] & 12'hFFC)
         `GPT_OFF_CFG: rd_mux = {29'h0, cfg_reg};
         `GPT_OFF_AMODE: rd_mux = {30'h0, amode_reg};
         `GPT_OFF_BMODE: rd_mux = {30'h0, bmode_reg};
         `GPT_OFF_CTL: rd_mux = {18'h0, ctl_reg};
         `GPT_OFF_MASK: rd_mux = {23'h0, mask_reg};
         `GPT_OFF_RAW: rd_mux = {23'h0, raw_reg};
         `GPT_OFF_MIS: rd_mux = {23'h0, raw_reg & mask_reg};
         `GPT_OFF_ALOAD: rd_mux = joined ? load32 : {16'h0, aload_reg};
         `GPT_OFF_BLOAD: rd_mux = {16'h0, bload_reg};
         `GPT_OFF_AMATCH: rd_mux = amatch_reg;
         `GPT_OFF_APRE: rd_mux = {24'h0, apre_reg};
         `GPT_OFF_BPRE: rd_mux = {24'h0, bpre_reg};
         `GPT_OFF_ACNT: rd_mux = joined ? cnt32 : {16'h0, acnt_reg};
         `GPT_OFF_BCNT: rd_mux = {16'h0, bcnt_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read data registered at end of address phase
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         rdata_reg <= 32'h00000000;
      else if (addr_ok & ~HWRITE)
         rdata_reg <= rd_mux;
   end

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   // plain writes; enables also cleared by oneshot expiry
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cfg_reg <= 3'h0;
         amode_reg <= 2'h0;
         bmode_reg <= 2'h0;
         mask_reg <= 9'h000;
         amatch_reg <= `GPT_RST_MATCH;
         apre_reg <= `GPT_RST_PRE;
         bpre_reg <= `GPT_RST_PRE;
      end
      else if (wr_reg)
      begin
         case (addr_reg)
            `GPT_OFF_CFG: cfg_reg <= HWDATA[2:0];
            `GPT_OFF_AMODE: amode_reg <= HWDATA[1:0];
            `GPT_OFF_BMODE: bmode_reg <= HWDATA[1:0];
            `GPT_OFF_MASK: mask_reg <= HWDATA[8:0];
            `GPT_OFF_AMATCH: amatch_reg <= HWDATA;
            `GPT_OFF_APRE: apre_reg <= HWDATA[7:0];
            `GPT_OFF_BPRE: bpre_reg <= HWDATA[7:0];
            default: cfg_reg <= cfg_reg;
         endcase
      end
   end

   // oneshot expiry clears enable; hardware clear wins over the write
   wire logic a_stop = (j_zero & j_oneshot) |
      (a_zero & (amode_reg == `GPT_MODE_ONESHOT));
   wire logic b_stop = b_zero & (bmode_reg == `GPT_MODE_ONESHOT);
   logic [13:0] ctl_next;
   always_comb
   begin
      ctl_next = wr_ctl ? HWDATA[13:0] : ctl_reg;
      if (a_stop)
         ctl_next[`GPT_CTL_AEN] = 1'b0;
      if (b_stop)
         ctl_next[`GPT_CTL_BEN] = 1'b0;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         ctl_reg <= 14'h0000;
      else
         ctl_reg <= ctl_next;
   end

   // sticky status; set wins over clear
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         raw_reg <= 9'h000;
      else
         raw_reg <= (raw_reg & ~(wr_clr ? HWDATA[8:0] : 9'h000))
            | ev_vec;
   end

   // load registers; joined write fills both halves
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         aload_reg <= `GPT_RST_CNT;
         bload_reg <= `GPT_RST_CNT;
      end
      else
      begin
         if (wr_load_a)
            aload_reg <= HWDATA[15:0];
         if (wr_load_a & joined)
            bload_reg <= HWDATA[31:16];
         else if (wr_load_b & ~joined)
            bload_reg <= HWDATA[15:0];
      end
   end

   // ----------------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------------
   logic [31:0] cnt_next;
   always_comb
   begin
      cnt_next = cnt32;
      case (join_st)
         gpt_pkg::GPT_J32:
         begin
            if (wr_load_a)
               cnt_next = HWDATA;
            else if (j_zero)
               cnt_next = load32;
            else if (j_run)
               cnt_next = cnt32 - 32'h00000001;
         end
         gpt_pkg::GPT_JRTC:
         begin
            if (!rtc_seen_reg)
               cnt_next = `GPT_RTC_FIRST;
            else if (r_match)
               cnt_next = 32'h00000000;
            else if (r_step)
               cnt_next = cnt32 + 32'h00000001;
         end
         gpt_pkg::GPT_SPLIT:
         begin
            if (wr_load_a)
               cnt_next[15:0] = HWDATA[15:0];
            else if (a_zero)
               cnt_next[15:0] = aload_reg;
            else if (a_tick)
               cnt_next[15:0] = acnt_reg - 16'h0001;
            if (wr_load_b)
               cnt_next[31:16] = HWDATA[15:0];
            else if (b_zero)
               cnt_next[31:16] = bload_reg;
            else if (b_tick)
               cnt_next[31:16] = bcnt_reg - 16'h0001;
         end
         default: cnt_next = cnt32;
      endcase
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         acnt_reg <= `GPT_RST_CNT;
         bcnt_reg <= `GPT_RST_CNT;
      end
      else
      begin
         acnt_reg <= cnt_next[15:0];
         bcnt_reg <= cnt_next[31:16];
      end
   end

   // prescale counters: reload on zero tick or load write
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         apc_reg <= `GPT_RST_PRE;
         bpc_reg <= `GPT_RST_PRE;
      end
      else
      begin
         if (a_tick | wr_load_a)
            apc_reg <= apre_reg;
         else if (a_run)
            apc_reg <= apc_reg - 8'h01;
         if (b_tick | wr_load_b)
            bpc_reg <= bpre_reg;
         else if (b_run)
            bpc_reg <= bpc_reg - 8'h01;
      end
   end

   // rtc first selection tracker, slow clock history, triggers
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rtc_seen_reg <= 1'b0;
         slow_reg <= 1'b0;
         trga_reg <= 1'b0;
         trgb_reg <= 1'b0;
      end
      else
      begin
         if (is_rtc)
            rtc_seen_reg <= 1'b1;
         else if (wr_cfg)
            rtc_seen_reg <= 1'b0;
         slow_reg <= SLOW_CLOCK_PIN;
         trga_reg <= ev_ato & ctl_reg[`GPT_CTL_ATRG];
         trgb_reg <= ev_bto & ctl_reg[`GPT_CTL_BTRG];
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign TRIGGER_A = trga_reg;
   assign TRIGGER_B = trgb_reg;
   assign TIMER_IRQ = |(raw_reg & mask_reg);
   assign CAPTURE_COMPARE_PIN_EVEN_EN = 1'b1;
   assign CAPTURE_COMPARE_PIN_ODD_EN = is_split;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_trig_one;
      @(posedge CLK) disable iff (!RESETN)
      TRIGGER_A |=> !TRIGGER_A;
   endproperty
   a_trig_one: assert property (p_trig_one)
      else $error("trigger a longer than one cycle");

   property p_j_reload;
      @(posedge CLK) disable iff (!RESETN)
      (j_zero && !wr_load_a) |=> (cnt32 == $past(load32));
   endproperty
   a_j_reload: assert property (p_j_reload)
      else $error("joined timer did not reload");

   property p_oneshot_stop;
      @(posedge CLK) disable iff (!RESETN)
      (j_zero && j_oneshot) |=> !a_en;
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop)
      else $error("oneshot did not clear enable");

   property p_raw_set;
      @(posedge CLK) disable iff (!RESETN)
      ev_ato |=> raw_reg[`GPT_ST_ATO];
   endproperty
   a_raw_set: assert property (p_raw_set)
      else $error("timeout flag not set");

   property p_rtc_roll;
      @(posedge CLK) disable iff (!RESETN)
      r_match |=> (cnt32 == 32'h00000000) && raw_reg[`GPT_ST_RTC];
   endproperty
   a_rtc_roll: assert property (p_rtc_roll)
      else $error("rtc did not roll over");

   property p_freeze;
      @(posedge CLK) disable iff (!RESETN)
      (!is_rtc && ctl_reg[`GPT_CTL_AFRZ] && !wr_load_a) |=>
         $stable(acnt_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("frozen count moved");

   property p_irq;
      @(posedge CLK) disable iff (!RESETN)
      (ev_bto && mask_reg[`GPT_ST_BTO] && !wr_reg) |=> TIMER_IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt missing");

   property p_pre_hold;
      @(posedge CLK) disable iff (!RESETN)
      (a_run && apc_reg != 8'h00 && !wr_load_a) |=> $stable(acnt_reg);
   endproperty
   a_pre_hold: assert property (p_pre_hold)
      else $error("count moved between prescale ticks");

   c_j_zero: cover property (@(posedge CLK) disable iff (!RESETN) j_zero);
   c_r_match: cover property (@(posedge CLK) disable iff (!RESETN) r_match);
   c_b_zero: cover property (@(posedge CLK) disable iff (!RESETN) b_zero);
endmodule

// ==== logic/gpt_cfg.svh ====
// register offsets, field positions, reset values and codes for the timer
// assumes byte addressing on a 32-bit AHB-Lite bus, one word per register
`ifndef GPT_CFG_SVH
`define GPT_CFG_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GPT_OFF_CFG 12'h000
`define GPT_OFF_AMODE 12'h004
`define GPT_OFF_BMODE 12'h008
`define GPT_OFF_CTL 12'h00C
`define GPT_OFF_MASK 12'h018
`define GPT_OFF_RAW 12'h01C
`define GPT_OFF_MIS 12'h020
`define GPT_OFF_CLR 12'h024
`define GPT_OFF_ALOAD 12'h028
`define GPT_OFF_BLOAD 12'h02C
`define GPT_OFF_AMATCH 12'h030
`define GPT_OFF_APRE 12'h038
`define GPT_OFF_BPRE 12'h03C
`define GPT_OFF_ACNT 12'h048
`define GPT_OFF_BCNT 12'h04C
// ----------------------------------------------------------------------
// configuration and mode codes
// ----------------------------------------------------------------------
`define GPT_CFG_32TMR 3'h0
`define GPT_CFG_32RTC 3'h1
`define GPT_CFG_16 3'h4
`define GPT_MODE_ONESHOT 2'h1
`define GPT_MODE_PERIODIC 2'h2
// ----------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------
`define GPT_CTL_AEN 0
`define GPT_CTL_AFRZ 1
`define GPT_CTL_RTCOVR 4
`define GPT_CTL_ATRG 5
`define GPT_CTL_BEN 8
`define GPT_CTL_BFRZ 9
`define GPT_CTL_BTRG 13
// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define GPT_ST_ATO 0
`define GPT_ST_RTC 3
`define GPT_ST_BTO 8
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GPT_RST_CNT 16'hFFFF
`define GPT_RST_PRE 8'h00
`define GPT_RTC_FIRST 32'h00000001
`define GPT_RST_MATCH 32'hFFFFFFFF
`endif

// ==== logic/gpt_pkg.sv ====
// types shared by the timer pair
// assumes gpt_cfg.svh supplies all numbers except the join state codes defined here
package gpt_pkg;
   // ----------------------------------------------------------------------
   // joined-mode state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      GPT_SPLIT = 3'b001,
      GPT_J32 = 3'b010,
      GPT_JRTC = 3'b100
   } gpt_join_t;
endpackage

// ==== tb/gpt_timer_tb_top.sv ====
// self-checking bench for the timer pair: bus tasks, scenarios and verdict
// assumes a zero-wait ahb-lite slave with the offsets of gpt_cfg.svh
`include "gpt_cfg.svh"
`define GPT_TB_CHK(got, exp, msg) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("[FAIL] %0t %s got %h", $time, msg, got); \
      end \
   end
module gpt_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // stimulus, observation and counters
   // ----------------------------------------------------------------------
   logic clk = 1'b0; // system clock, 100 MHz
   logic resetn = 1'b0; // held low at start
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   logic slow_pin = 1'b0; // slow clock level, toggled by hand
   wire logic [31:0] hrdata;
   wire logic hready; // hreadyout fed back as hready
   wire logic hresp;
   wire logic trig_a;
   wire logic trig_b;
   wire logic irq;
   wire logic even_en;
   wire logic odd_en;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [31:0] v0; // read-back scratch
   logic [31:0] v1;
   localparam logic [31:0] AEN = 32'h1 << `GPT_CTL_AEN;
   localparam logic [31:0] AFRZ = 32'h1 << `GPT_CTL_AFRZ;
   localparam logic [31:0] OVR = 32'h1 << `GPT_CTL_RTCOVR;
   localparam logic [31:0] ATRG = 32'h1 << `GPT_CTL_ATRG;
   localparam logic [31:0] BEN = 32'h1 << `GPT_CTL_BEN;
   localparam logic [31:0] BTRG = 32'h1 << `GPT_CTL_BTRG;
   localparam logic [31:0] BFRZ = 32'h1 << `GPT_CTL_BFRZ;
   // clock: invert every half period
   always #5 clk = ~clk;
   // ----------------------------------------------------------------------
   // device under test
   // ----------------------------------------------------------------------
   gpt_timer DUT
   (
      .CLK(clk),
      .RESETN(resetn),
      .HSEL(1'b1),
      .HADDR(haddr),
      .HTRANS(htrans),
      .HWRITE(hwrite),
      .HSIZE(3'h2),
      .HREADY(hready),
      .HWDATA(hwdata),
      .HRDATA(hrdata),
      .HREADYOUT(hready),
      .HRESP(hresp),
      .SLOW_CLOCK_PIN(slow_pin),
      .TRIGGER_A(trig_a),
      .TRIGGER_B(trig_b),
      .TIMER_IRQ(irq),
      .CAPTURE_COMPARE_PIN_EVEN_EN(even_en),
      .CAPTURE_COMPARE_PIN_ODD_EN(odd_en)
   );
   // ----------------------------------------------------------------------
   // bus tasks: entered just after a rising edge
   // ----------------------------------------------------------------------
   // one single-word transfer, held until hready is seen at each phase
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      q = hrdata;
      `GPT_TB_CHK(hresp, 1'b0, "bus response")
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h00000000, q);
   endtask
   // wait on falling edges for a trigger line, then see it drop
   task automatic see_pulse(input bit b, output int n);
      n = 0;
      @(negedge clk);
      while ((b ? trig_b : trig_a) !== 1'b1 && n < 400)
      begin
         n++;
         @(negedge clk);
      end
      `GPT_TB_CHK(b ? trig_b : trig_a, 1'b1, "trigger seen")
      @(negedge clk);
      `GPT_TB_CHK(b ? trig_b : trig_a, 1'b0, "trigger one cycle")
      @(posedge clk);
   endtask
   // one slow clock period of eight system clocks
   task automatic slow_tick();
      slow_pin <= 1'b1;
      repeat (4) @(posedge clk);
      slow_pin <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   // reset values, unmapped place and joined pin use
   task automatic t_reset();
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'hFFFFFFFF, "joined count at reset")
      rd(`GPT_OFF_BLOAD, v0);
      `GPT_TB_CHK(v0[15:0], `GPT_RST_CNT, "b load at reset")
      rd(`GPT_OFF_APRE, v0);
      `GPT_TB_CHK(v0[7:0], `GPT_RST_PRE, "a prescale reset")
      rd(`GPT_OFF_BPRE, v0);
      `GPT_TB_CHK(v0[7:0], `GPT_RST_PRE, "b prescale reset")
      rd(`GPT_OFF_CTL, v0);
      `GPT_TB_CHK(v0, 32'h00000000, "control at reset")
      rd(12'h0FC, v0);
      `GPT_TB_CHK(v0, 32'h00000000, "unmapped read")
      `GPT_TB_CHK(odd_en, 1'b0, "odd pin joined")
      `GPT_TB_CHK(even_en, 1'b1, "even pin joined")
   endtask
   // joined one-shot with b asking periodic, mask and clear
   task automatic t_j32_oneshot();
      int n;
      wr(`GPT_OFF_CFG, {29'h0, `GPT_CFG_32TMR});
      wr(`GPT_OFF_AMODE, {30'h0, `GPT_MODE_ONESHOT});
      wr(`GPT_OFF_BMODE, {30'h0, `GPT_MODE_PERIODIC});
      wr(`GPT_OFF_ALOAD, 32'h00030005);
      rd(`GPT_OFF_BLOAD, v0);
      `GPT_TB_CHK(v0[15:0], 16'h0003, "upper half to b load")
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'h00030005, "joined count read")
      wr(`GPT_OFF_ALOAD, 32'h00000005);
      wr(`GPT_OFF_CTL, AEN | ATRG);
      see_pulse(1'b0, n);
      repeat (3) @(posedge clk);
      rd(`GPT_OFF_CTL, v0);
      `GPT_TB_CHK(v0[`GPT_CTL_AEN], 1'b0, "one-shot stops")
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'h00000005, "reload after zero")
      rd(`GPT_OFF_RAW, v0);
      `GPT_TB_CHK(v0[`GPT_ST_ATO], 1'b1, "raw timeout")
      `GPT_TB_CHK(irq, 1'b0, "masked off irq")
      wr(`GPT_OFF_MASK, 32'h1 << `GPT_ST_ATO);
      rd(`GPT_OFF_MIS, v0);
      `GPT_TB_CHK(v0[`GPT_ST_ATO], 1'b1, "masked timeout")
      `GPT_TB_CHK(irq, 1'b1, "irq on mask")
      wr(`GPT_OFF_CLR, 32'h1 << `GPT_ST_ATO);
      rd(`GPT_OFF_RAW, v0);
      `GPT_TB_CHK(v0[`GPT_ST_ATO], 1'b0, "timeout cleared")
      `GPT_TB_CHK(irq, 1'b0, "irq cleared")
   endtask
   // joined periodic: freeze, release and load while running
   task automatic t_j32_freeze();
      wr(`GPT_OFF_AMODE, {30'h0, `GPT_MODE_PERIODIC});
      wr(`GPT_OFF_ALOAD, 32'h00010000);
      wr(`GPT_OFF_CTL, AEN | AFRZ);
      rd(`GPT_OFF_ACNT, v0);
      repeat (10) @(posedge clk);
      rd(`GPT_OFF_ACNT, v1);
      `GPT_TB_CHK(v1, v0, "frozen count holds")
      wr(`GPT_OFF_CTL, AEN);
      repeat (10) @(posedge clk);
      rd(`GPT_OFF_ACNT, v1);
      `GPT_TB_CHK(v1 < v0, 1'b1, "count resumes downward")
      wr(`GPT_OFF_ALOAD, 32'h00002000);
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0 <= 32'h00002000 && v0 > 32'h00001FF0, 1'b1,
                  "running load taken")
      wr(`GPT_OFF_CTL, 32'h00000000);
   endtask
   // split: prescale rate, b periodic period, b one-shot and flags
   task automatic t_split();
      int n;
      wr(`GPT_OFF_CFG, {29'h0, `GPT_CFG_16});
      wr(`GPT_OFF_AMODE, {30'h0, `GPT_MODE_PERIODIC});
      `GPT_TB_CHK(odd_en, 1'b1, "odd pin split")
      wr(`GPT_OFF_APRE, 32'h00000003);
      wr(`GPT_OFF_ALOAD, 32'h0000FFFF);
      wr(`GPT_OFF_BMODE, {30'h0, `GPT_MODE_PERIODIC});
      wr(`GPT_OFF_BLOAD, 32'h00000002);
      wr(`GPT_OFF_MASK, 32'h1 << `GPT_ST_BTO);
      wr(`GPT_OFF_CTL, AEN | BEN | BTRG);
      rd(`GPT_OFF_ACNT, v0);
      repeat (38) @(posedge clk);
      rd(`GPT_OFF_ACNT, v1);
      `GPT_TB_CHK(v0[15:0] - v1[15:0], 16'h000A, "prescale four")
      see_pulse(1'b1, n);
      see_pulse(1'b1, n);
      `GPT_TB_CHK(n, 1, "b period of three clocks")
      rd(`GPT_OFF_RAW, v0);
      `GPT_TB_CHK(v0[`GPT_ST_BTO], 1'b1, "b raw timeout")
      `GPT_TB_CHK(irq, 1'b1, "b irq")
      wr(`GPT_OFF_BMODE, {30'h0, `GPT_MODE_ONESHOT});
      see_pulse(1'b1, n);
      repeat (3) @(posedge clk);
      rd(`GPT_OFF_CTL, v0);
      `GPT_TB_CHK(v0[`GPT_CTL_BEN], 1'b0, "b one-shot stops")
      `GPT_TB_CHK(v0[`GPT_CTL_AEN], 1'b1, "a keeps running")
      wr(`GPT_OFF_CTL, AEN | AFRZ | BEN | BFRZ);
      rd(`GPT_OFF_ACNT, v0);
      repeat (8) @(posedge clk);
      rd(`GPT_OFF_ACNT, v1);
      `GPT_TB_CHK(v1, v0, "split a frozen")
      rd(`GPT_OFF_BCNT, v1);
      `GPT_TB_CHK(v1, 32'h00000002, "split b frozen")
      wr(`GPT_OFF_CTL, 32'h00000000);
      wr(`GPT_OFF_CLR, 32'h1 << `GPT_ST_BTO);
   endtask
   // rtc: first load, slow-edge count, match rollover, override
   task automatic t_rtc();
      wr(`GPT_OFF_CFG, {29'h0, `GPT_CFG_32RTC});
      wr(`GPT_OFF_AMATCH, 32'h00000003);
      wr(`GPT_OFF_MASK, 32'h1 << `GPT_ST_RTC);
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, `GPT_RTC_FIRST, "rtc first load")
      wr(`GPT_OFF_CTL, AEN);
      repeat (10) @(posedge clk);
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, `GPT_RTC_FIRST, "no count without edge")
      slow_tick();
      slow_tick();
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'h00000003, "rtc counts up")
      slow_tick();
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'h00000000, "rtc rolls to zero")
      rd(`GPT_OFF_RAW, v0);
      `GPT_TB_CHK(v0[`GPT_ST_RTC], 1'b1, "rtc match flag")
      `GPT_TB_CHK(irq, 1'b1, "rtc irq")
      wr(`GPT_OFF_CLR, 32'h1 << `GPT_ST_RTC);
      rd(`GPT_OFF_MIS, v0);
      `GPT_TB_CHK(v0[`GPT_ST_RTC], 1'b0, "rtc flag cleared")
      wr(`GPT_OFF_CTL, AEN | AFRZ | OVR);
      slow_tick();
      rd(`GPT_OFF_ACNT, v0);
      `GPT_TB_CHK(v0, 32'h00000001, "override ignores freeze")
   endtask
   // ----------------------------------------------------------------------
   // verdict and main sequence
   // ----------------------------------------------------------------------
   task automatic summarize();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: the whole run needs a few hundred cycles
   initial
   begin
      #200000;
      n_mismatch++;
      summarize();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_j32_oneshot();
      t_j32_freeze();
      t_split();
      t_rtc();
      summarize();
   end
endmodule
